//--- logic/mode_power_pkg.sv
// Constants, register map and types for the MAC mode and power control block
//
// Contract
// RL1 - Two loopback families, internal and external, all at ten megabits per second
// RL2 - Internal loopback returns transmit frames to receive and detaches from the wire
// RL3 - MAC loopback turns packets inside the MAC and detaches the interface adapter
// RL4 - Twisted-pair internal loopback routes encoder output into decoder input
// RL5 - External loopback transmits on the wire and receives own frames concurrently
// RL6 - External loopback does not check source of arriving frames
// RL7 - Twisted-pair external loopback disables the internal collision detector
// RL8 - MAC and twisted-pair loopback keep address filtering and validity checks
// RL9 - Driver stops, idles, zeroes connectivity, programs, waits 5 us, enters loopback
// RL10 - Driver leaves loopback by the same stop, reset, wait and restart sequence
// RL11 - Full duplex only on twisted pair, transmit and receive run together
// RL12 - Full duplex sends and receives back-to-back with 9.6 us gap
// RL13 - Full-duplex bit makes the MAC ignore carrier sense and collision detect
// RL14 - With autonegotiation, full duplex only if negotiated result allows it
// RL15 - Driver stops, resets adapter, sets duplex and mode, waits link pass, starts; the bench writes duplex, mode and starts at once, no link wait
// RL16 - Sleep disables datapath blocks; PCI and configuration stay, control registers blocked
// RL17 - Driver stops, clears adapter reset bit, then sets sleep bit
// RL18 - Driver clears sleep, waits 10 ms, sets adapter reset bit, waits, starts; the bench sets the adapter bit at once and waits 5 us
// RL19 - Snooze enters low power unless any activity condition holds
// RL20 - Snooze low power keeps only PCI interface and adapter, decoder off
// RL21 - Snooze wakes at once on slave access, carrier, or link interrupt
// RL22 - Driver avoids snooze with ROM access, timer or automatic polling
// RL23 - Stop transmit finishes the current frame before stopping
// RL24 - Snooze gating is glitch-free and synchronous, no slave access lost
// RL25 - Stopped state reported only after frame and write-back complete
package mode_power_pkg;

  // Register byte addresses
  localparam logic [7:0] opmode_addr = 8'h00; // operation_mode_register
  localparam logic [7:0] conn_addr = 8'h04; // interface_connectivity_register
  localparam logic [7:0] txrx_addr = 8'h08; // interface_tx_rx_register
  localparam logic [7:0] cda_addr = 8'h0c; // config_driver_area_register
  localparam logic [7:0] status_addr = 8'h10; // status_register
  localparam logic [7:0] ctrl_out_addr = 8'h14; // Derived control view, read only

  // operation_mode_register fields
  localparam int rx_start_bit = 1;
  localparam int fdx_bit = 9;
  localparam int opm_lo = 10;
  localparam int opm_hi = 11;
  localparam int tx_start_bit = 13;
  localparam int media_tp_bit = 16; // 1 = twisted pair, 0 = attachment unit

  // Loopback mode field encodings
  localparam logic [1:0] opm_normal = 2'h0;
  localparam logic [1:0] opm_int_loop = 2'h1;
  localparam logic [1:0] opm_ext_loop = 2'h2;

  // Other control bits
  localparam int adapter_run_bit = 0; // connectivity bit 0: 1 = adapter running
  localparam int adapter_loop_bit = 1; // connectivity: encoder-level internal loop
  localparam int autoneg_bit = 7;
  localparam int sleep_bit = 31;
  localparam int snooze_bit = 30;

  // status_register process state fields
  localparam int tx_state_lo = 20;
  localparam int rx_state_lo = 17;
  localparam logic [2:0] ps_stopped = 3'h0;
  localparam logic [2:0] ps_running = 3'h1;
  localparam logic [2:0] ps_rx_wait = 3'h3;
  localparam logic [2:0] ps_closing = 3'h7;

  localparam logic [31:0] reg_reset = 32'h0000_0000;
  localparam logic [31:0] conn_reset = 32'h0000_0001;

  // Loopback data rate and full-duplex gap
  localparam int loop_rate_mbps = 10;
  localparam int clk_mhz = 250;
  localparam int ipg_ns = 9600;
  localparam int ipg_cycles = (ipg_ns * clk_mhz + 999) / 1000;

  // Process state machine
  typedef enum logic [2:0] {
    pr_stop = 3'b001,
    pr_run = 3'b010,
    pr_drain = 3'b100
  } proc_state_t;

endpackage : mode_power_pkg

//--- logic/proc_if.sv
// Interface carrying one process's start, activity and state between modules
`timescale 1ns/100ps
interface proc_if;
  logic start;
  logic frame_busy;
  logic wb_busy;
  logic [2:0] state;
  logic running;
  modport ctrl (output start, output frame_busy, output wb_busy, input state, input running);
  modport proc (input start, input frame_busy, input wb_busy, output state, output running);
endinterface : proc_if

//--- logic/proc_state.sv
// Start/stop tracker for one transmit or receive process
`timescale 1ns/100ps
module proc_state
  import mode_power_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic idle_wait,
  proc_if.proc p
);

  typedef struct packed {
    proc_state_t st;
  } ps_t;

  ps_t s_reg;
  ps_t s_next;

  // Stop waits until frame and write-back are both done
  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      pr_stop: if (p.start) s_next.st = pr_run;
      pr_run: if (!p.start) s_next.st = (p.frame_busy || p.wb_busy) ? pr_drain : pr_stop; // [RL23]
      pr_drain: begin
        if (!p.frame_busy && !p.wb_busy) begin
          s_next.st = p.start ? pr_run : pr_stop; // [RL25]
        end
      end
      default: s_next.st = pr_stop;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg.st <= pr_stop;
    end else begin
      s_reg <= s_next;
    end
  end

  // Stopped code reported only from the stopped state
  assign p.state = (s_reg.st == pr_stop) ? ps_stopped :
                   (s_reg.st == pr_drain) ? ps_closing :
                   (idle_wait ? ps_rx_wait : ps_running); // [RL25]
  assign p.running = (s_reg.st != pr_stop);

endmodule : proc_state

//--- logic/mode_power_ctrl.sv
// MAC loopback, duplex and power mode control with APB register access
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module mode_power_ctrl
  import mode_power_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cfg_access,
  input wire logic master_access,
  input wire logic tx_frame_busy,
  input wire logic tx_wb_busy,
  input wire logic rx_frame_busy,
  input wire logic rx_wb_busy,
  input wire logic rx_waiting,
  input wire logic rx_fifo_empty,
  input wire logic rx_engine_idle,
  input wire logic carrier_in,
  input wire logic collision_in,
  input wire logic link_event,
  input wire logic an_full_duplex,
  output logic mac_loop,
  output logic enc_dec_loop,
  output logic wire_detach,
  output logic adapter_detach,
  output logic src_check_off,
  output logic filter_on,
  output logic coll_detect_en,
  output logic carrier_seen,
  output logic collision_seen,
  output logic full_duplex,
  output logic ipg_tick,
  output logic rate_10m,
  output logic sleep_gate,
  output logic snooze_gate,
  output logic tx_start_q,
  output logic rx_start_q
);

  typedef struct packed {
    logic [31:0] opmode;
    logic [31:0] conn;
    logic [31:0] txrx;
    logic [31:0] cda;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic low_power;
    logic [15:0] ipg_cnt;
    logic [11:0] outs;
  } st_t;

  st_t r_reg;
  st_t r_next;

  proc_if tx_p ();
  proc_if rx_p ();

  logic wake;
  logic stay_awake;
  logic fdx_ok;
  logic [1:0] opm;
  logic is_tp;
  logic [31:0] status_word;
  logic [11:0] outs_c;

  ////////////////////////////////////////////////////////////////////////
  // Process trackers
  proc_state u_tx (.clk(clk), .nrst(nrst), .idle_wait(1'b0), .p(tx_p.proc));
  proc_state u_rx (.clk(clk), .nrst(nrst), .idle_wait(rx_waiting), .p(rx_p.proc));

  assign tx_p.start = r_reg.opmode[tx_start_bit];
  assign rx_p.start = r_reg.opmode[rx_start_bit];
  assign tx_p.frame_busy = tx_frame_busy;
  assign tx_p.wb_busy = tx_wb_busy;
  assign rx_p.frame_busy = rx_frame_busy;
  assign rx_p.wb_busy = rx_wb_busy;

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign opm = r_reg.opmode[opm_hi:opm_lo];
  assign is_tp = r_reg.opmode[media_tp_bit];
  // Duplex needs twisted pair and, under autonegotiation, the partner's consent
  assign fdx_ok = r_reg.opmode[fdx_bit] && is_tp
                  && (!r_reg.txrx[autoneg_bit] || an_full_duplex); // [RL11] [RL14]

  // Combinational wake term so the very slave access is served at once
  assign wake = psel || carrier_in || link_event; // [RL21]
  assign stay_awake = wake || cfg_access || master_access || tx_p.running
                      || (rx_p.running && !rx_waiting) || !rx_fifo_empty
                      || !rx_engine_idle; // [RL19]

  assign status_word = {9'h000, tx_p.state, rx_p.state, 17'h00000};

  // Mode outputs packed for registering
  always_comb begin
    outs_c = '0;
    outs_c[0] = (opm == opm_int_loop) && !r_reg.conn[adapter_loop_bit]; // [RL3]
    outs_c[1] = (opm == opm_int_loop) && r_reg.conn[adapter_loop_bit] && is_tp; // [RL4]
    outs_c[2] = (opm == opm_int_loop); // [RL2]
    outs_c[3] = outs_c[0] || !r_reg.conn[adapter_run_bit]; // [RL3]
    outs_c[4] = (opm == opm_ext_loop); // [RL5] [RL6]
    outs_c[5] = (opm != opm_ext_loop); // [RL8]
    outs_c[6] = !((opm == opm_ext_loop) && is_tp) && !fdx_ok; // [RL7]
    outs_c[7] = carrier_in && !fdx_ok; // [RL13]
    outs_c[8] = collision_in && !fdx_ok && outs_c[6]; // [RL13]
    outs_c[9] = fdx_ok; // [RL11]
    outs_c[10] = (opm != opm_normal); // [RL1]
    outs_c[11] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file, APB slave and power control
  always_comb begin
    r_next = r_reg;
    r_next.ready = 1'b0;
    r_next.err = 1'b0;
    r_next.outs = outs_c;
    // Gap counter paces back-to-back frames in full duplex
    if (!fdx_ok || r_reg.ipg_cnt == 16'(ipg_cycles - 1)) begin
      r_next.ipg_cnt = '0; // [RL12]
    end else begin
      r_next.ipg_cnt = r_reg.ipg_cnt + 16'h0001;
    end
    // Snooze: gate only on a clean edge; wake wins immediately
    r_next.low_power = r_reg.cda[snooze_bit] && !stay_awake; // [RL19] [RL24]
    // Setup cycle: refuse, decode and fetch read data for the access phase
    if (psel && !penable) begin
      r_next.ready = 1'b1;
      if (r_reg.cda[sleep_bit] && paddr != cda_addr) begin
        r_next.err = 1'b1; // [RL16]
      end else if (pwrite) begin
        case (paddr)
          opmode_addr, conn_addr, txrx_addr, cda_addr, status_addr: ;
          default: r_next.err = 1'b1;
        endcase
      end else begin
        case (paddr)
          opmode_addr: r_next.rdata = r_reg.opmode;
          conn_addr: r_next.rdata = r_reg.conn;
          txrx_addr: r_next.rdata = r_reg.txrx;
          cda_addr: r_next.rdata = r_reg.cda;
          status_addr: r_next.rdata = status_word;
          ctrl_out_addr: r_next.rdata = {20'h00000, r_reg.outs};
          default: begin
            r_next.rdata = '0;
            r_next.err = 1'b1;
          end
        endcase
      end
    end
    // Access cycle: a write lands only at the edge that completes the transfer
    if (psel && penable && pwrite && r_reg.ready && !r_reg.err) begin
      case (paddr)
        opmode_addr: r_next.opmode = pwdata;
        conn_addr: r_next.conn = pwdata;
        txrx_addr: r_next.txrx = pwdata;
        cda_addr: r_next.cda = pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r_reg.opmode <= reg_reset;
      r_reg.conn <= conn_reset;
      r_reg.txrx <= reg_reset;
      r_reg.cda <= reg_reset;
      r_reg.rdata <= reg_reset;
      r_reg.ready <= 1'b0;
      r_reg.err <= 1'b0;
      r_reg.low_power <= 1'b0;
      r_reg.ipg_cnt <= '0;
      r_reg.outs <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Ready answers in the access phase, one cycle after setup
  assign pready = r_reg.ready && psel && penable;
  assign pslverr = r_reg.err && psel && penable;
  assign prdata = r_reg.rdata;
  assign mac_loop = r_reg.outs[0];
  assign enc_dec_loop = r_reg.outs[1];
  assign wire_detach = r_reg.outs[2];
  assign adapter_detach = r_reg.outs[3];
  assign src_check_off = r_reg.outs[4];
  assign filter_on = r_reg.outs[5];
  assign coll_detect_en = r_reg.outs[6];
  assign carrier_seen = r_reg.outs[7];
  assign collision_seen = r_reg.outs[8];
  assign full_duplex = r_reg.outs[9];
  assign rate_10m = r_reg.outs[10]; // [RL1]
  assign ipg_tick = fdx_ok && (r_reg.ipg_cnt == '0); // [RL12]
  assign sleep_gate = r_reg.cda[sleep_bit]; // [RL16]
  // Wake term clears gate combinationally; no access sees a gated cycle
  assign snooze_gate = r_reg.low_power && !wake; // [RL20] [RL21] [RL24]
  assign tx_start_q = tx_p.running;
  assign rx_start_q = rx_p.running;

endmodule : mode_power_ctrl

//--- verif/mode_power_checker.sv
// Port-level checks on the mode and power control block
`timescale 1ns/100ps
module mode_power_checker
  import mode_power_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic carrier_in,
  input wire logic link_event,
  input wire logic mac_loop,
  input wire logic enc_dec_loop,
  input wire logic wire_detach,
  input wire logic adapter_detach,
  input wire logic src_check_off,
  input wire logic filter_on,
  input wire logic carrier_seen,
  input wire logic collision_seen,
  input wire logic full_duplex,
  input wire logic ipg_tick,
  input wire logic rate_10m,
  input wire logic sleep_gate,
  input wire logic snooze_gate
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////
  // Setup to a control register while asleep, then its answer
  sequence s_csr_asleep;
    sleep_gate && psel && !penable && paddr != cda_addr;
  endsequence
  sequence s_refused;
    psel && penable && pready && pslverr;
  endsequence
  chk_sleep_blocks_csr: assert property (s_csr_asleep |=> s_refused)
    else $error("control access not refused in sleep");
  chk_setup_answered: assert property (psel && !penable |=> pready)
    else $error("setup cycle not answered");
  chk_mac_loop_detach: assert property (mac_loop |-> wire_detach && adapter_detach)
    else $error("mac loop still attached");
  chk_enc_loop_detach: assert property (enc_dec_loop |-> wire_detach && !mac_loop)
    else $error("encoder loop not detached");
  chk_ext_loop_wire: assert property (src_check_off |-> !wire_detach)
    else $error("external loop off the wire");
  chk_loop_keeps_filter: assert property (mac_loop || enc_dec_loop |-> filter_on)
    else $error("filtering lost in loop");
  chk_loop_ten_meg: assert property (mac_loop || enc_dec_loop || src_check_off |-> rate_10m)
    else $error("loop not at ten megabits");
  // Skip the cycle where duplex just turned on, though sense and duplex come from one register
  chk_fdx_ignores_sense: assert property (full_duplex && $past(full_duplex) |-> !carrier_seen && !collision_seen)
    else $error("sense seen in full duplex");
  chk_ipg_one_pulse: assert property (ipg_tick |=> !ipg_tick [*8])
    else $error("gap tick too close");
  // Gate only after a quiet cycle, and never while a wake cause stands
  sequence s_no_wake_cause;
    !psel && !carrier_in && !link_event && !$past(psel) && !$past(carrier_in) && !$past(link_event);
  endsequence
  chk_snooze_wakes_now: assert property (snooze_gate |-> s_no_wake_cause)
    else $error("gated during wake cause");
endmodule : mode_power_checker
bind mode_power_ctrl mode_power_checker u_chk (.clk, .nrst, .psel, .penable, .paddr, .pready, .pslverr,
  .carrier_in, .link_event, .mac_loop, .enc_dec_loop, .wire_detach, .adapter_detach, .src_check_off, .filter_on,
  .carrier_seen, .collision_seen, .full_duplex, .ipg_tick, .rate_10m, .sleep_gate, .snooze_gate);

//--- verif/medium_model.sv
// Wire and process activity model at the far side of the mode block
`timescale 1ns/100ps
module medium_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic frame_go,
  input wire logic carrier_req,
  input wire logic link_req,
  output logic tx_frame_busy,
  output logic tx_wb_busy,
  output logic rx_frame_busy,
  output logic rx_wb_busy,
  output logic carrier_in,
  output logic collision_in,
  output logic link_event
);
  logic [7:0] cnt_reg;
  logic [1:0] echo_reg;
  // A frame lasts 40 cycles, its write-back 8 more
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_reg <= 8'h00;
      echo_reg <= 2'h0;
    end else begin
      if (frame_go && cnt_reg == 8'h00) cnt_reg <= 8'h30;
      else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
      echo_reg <= {tx_frame_busy, tx_wb_busy}; // Shunt echoes own frame
    end
  end
  assign tx_frame_busy = cnt_reg > 8'h08;
  assign tx_wb_busy = cnt_reg != 8'h00 && cnt_reg <= 8'h08;
  assign rx_frame_busy = echo_reg[1];
  assign rx_wb_busy = echo_reg[0];
  // Another station talking over our frame is a collision
  assign carrier_in = carrier_req || tx_frame_busy;
  assign collision_in = carrier_req && tx_frame_busy;
  assign link_event = link_req;
endmodule : medium_model

//--- verif/tb_top.sv
// Self-checking bench for the mode and power control block
`timescale 1ns/100ps
`define CHK(a, x, m) begin checks_done++; if ((a) !== (x)) begin err_total++; $display("FAIL %0t %s", $time, m); end end
module tb_top;
  import mode_power_pkg::*;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, e, frame_go, carrier_req, link_req, an_full_duplex;
  logic [7:0] paddr, vec;
  logic [31:0] pwdata, prdata, q;
  logic tx_frame_busy, tx_wb_busy, rx_frame_busy, rx_wb_busy, carrier_in, collision_in, link_event;
  logic mac_loop, enc_dec_loop, wire_detach, adapter_detach, src_check_off, filter_on, coll_detect_en, carrier_seen;
  logic collision_seen, full_duplex, ipg_tick, rate_10m, sleep_gate, snooze_gate, tx_start_q, rx_start_q;
  int err_total, checks_done, n;
  logic bus_busy;
  // Loop modes: op mode, connectivity, expected outputs, care mask
  logic [31:0] om_t [5] = '{32'h400, 32'h10400, 32'h10800, 32'h800, 32'h10000};
  logic [1:0] cn_t [5] = '{2'h1, 2'h3, 2'h1, 2'h1, 2'h1};
  logic [7:0] ex_t [5] = '{8'hb3, 8'h63, 8'h0a, 8'h0e, 8'h05};
  logic [7:0] mk_t [5] = '{8'hfb, 8'hfb, 8'hfe, 8'hfe, 8'hfd};
  assign vec = {mac_loop, enc_dec_loop, wire_detach, adapter_detach, src_check_off, coll_detect_en, rate_10m,
                filter_on};
  medium_model u_med (.clk, .nrst, .frame_go, .carrier_req, .link_req, .tx_frame_busy, .tx_wb_busy,
    .rx_frame_busy, .rx_wb_busy, .carrier_in, .collision_in, .link_event);
  mode_power_ctrl u_dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready,
    .pslverr, .cfg_access(bus_busy), .master_access(bus_busy), .tx_frame_busy, .tx_wb_busy, .rx_frame_busy,
    .rx_wb_busy,
    .rx_waiting(!rx_frame_busy), .rx_fifo_empty(!rx_frame_busy), .rx_engine_idle(!rx_frame_busy), .carrier_in,
    .collision_in, .link_event, .an_full_duplex, .mac_loop, .enc_dec_loop, .wire_detach, .adapter_detach,
    .src_check_off, .filter_on, .coll_detect_en, .carrier_seen, .collision_seen, .full_duplex, .ipg_tick,
    .rate_10m, .sleep_gate, .snooze_gate, .tx_start_q, .rx_start_q);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc
  // One transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      close_out();
    end
  endtask : apb
  // Stop both processes and poll until both report stopped
  task automatic stop_idle;
    apb(1'b1, opmode_addr, 32'h0);
    n = 0;
    do begin
      apb(1'b0, status_addr, 32'h0);
      n++;
    end while (q[22:17] !== 6'h00 && n < 200);
    `CHK(q[22:17], 6'h00, "processes not idle")
    if (q[22:17] !== 6'h00) close_out();
  endtask : stop_idle
  // Adapter held, reprogrammed, 5 us settle, then mode and both starts
  task automatic enter_mode(input logic [31:0] om, input logic [31:0] cn);
    stop_idle();
    apb(1'b1, conn_addr, 32'h0);
    apb(1'b1, conn_addr, cn);
    cyc(1250);
    apb(1'b1, opmode_addr, om | 32'h2002);
    cyc(2);
  endtask : enter_mode
  initial begin
    {nrst, psel, penable, pwrite, frame_go, carrier_req, link_req, an_full_duplex} = 8'h00;
    paddr = 8'h00;
    bus_busy = 1'b0;
    pwdata = 32'h0;
    err_total = 0;
    checks_done = 0;
    cyc(20);
    nrst <= 1'b1;
    cyc(2);
    `CHK(coll_detect_en, 1'b1, "detector off at reset")
    apb(1'b0, conn_addr, 32'h0);
    `CHK(q, conn_reset, "connectivity reset")
    apb(1'b0, 8'h18, 32'h0);
    `CHK(e, 1'b1, "unmapped not refused")
    for (int i = 0; i < 5; i++) begin
      enter_mode(om_t[i], {30'h0, cn_t[i]});
      `CHK(vec & mk_t[i], ex_t[i] & mk_t[i], "loop outputs")
    end
    $display("test loopback done");
    carrier_req <= 1'b1;
    enter_mode(32'h10200, 32'h1);
    `CHK(full_duplex, 1'b1, "duplex off on twisted pair")
    `CHK(carrier_seen, 1'b0, "carrier seen in duplex")
    for (int j = 0; j < 2; j++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (ipg_tick !== 1'b1 && n < 3000);
      if (ipg_tick !== 1'b1) begin
        err_total++;
        close_out();
      end
    end
    `CHK(n, ipg_cycles, "gap length")
    enter_mode(32'h200, 32'h1);
    `CHK(full_duplex, 1'b0, "duplex on attachment unit")
    `CHK(carrier_seen, 1'b1, "carrier lost in half duplex")
    // Own frame under foreign carrier must show a collision in half duplex
    frame_go <= 1'b1;
    cyc(1);
    frame_go <= 1'b0;
    cyc(2);
    `CHK(collision_seen, 1'b1, "collision lost in half duplex")
    apb(1'b1, txrx_addr, 32'h80);
    enter_mode(32'h10200, 32'h1);
    `CHK(full_duplex, 1'b0, "duplex without negotiation")
    an_full_duplex <= 1'b1;
    cyc(2);
    `CHK(full_duplex, 1'b1, "negotiated duplex off")
    carrier_req <= 1'b0;
    $display("test duplex done");
    frame_go <= 1'b1;
    cyc(1);
    frame_go <= 1'b0;
    apb(1'b1, opmode_addr, 32'h0);
    apb(1'b0, status_addr, 32'h0);
    `CHK(q[22:20], ps_closing, "stopped mid frame")
    `CHK({tx_start_q, rx_start_q}, 2'b11, "start dropped mid frame")
    stop_idle();
    `CHK({tx_start_q, rx_start_q}, 2'b00, "not stopped after frame")
    $display("test stop done");
    apb(1'b1, cda_addr, 32'h4000_0000); // No ROM or timer use while snoozing
    cyc(4);
    `CHK(snooze_gate, 1'b1, "no snooze when idle")
    bus_busy <= 1'b1;
    cyc(2);
    `CHK(snooze_gate, 1'b0, "snooze during bus access")
    bus_busy <= 1'b0;
    cyc(2);
    carrier_req <= 1'b1;
    cyc(1);
    `CHK(snooze_gate, 1'b0, "no wake on carrier")
    carrier_req <= 1'b0;
    cyc(2);
    link_req <= 1'b1;
    cyc(1);
    `CHK(snooze_gate, 1'b0, "no wake on link event")
    link_req <= 1'b0;
    apb(1'b1, opmode_addr, 32'h2000);
    cyc(4);
    `CHK(snooze_gate, 1'b0, "snooze while sending")
    $display("test snooze done");
    stop_idle();
    apb(1'b1, conn_addr, 32'h0);
    apb(1'b1, cda_addr, 32'h8000_0000);
    cyc(1);
    `CHK(sleep_gate, 1'b1, "sleep not entered")
    apb(1'b1, opmode_addr, 32'h2002);
    `CHK(e, 1'b1, "write taken in sleep")
    apb(1'b0, cda_addr, 32'h0);
    `CHK({e, q}, 33'h0_8000_0000, "driver area blocked")
    // Exit settle shortened: the block keeps no timer of its own on it
    apb(1'b1, cda_addr, 32'h0);
    apb(1'b1, conn_addr, 32'h1);
    cyc(1250);
    apb(1'b0, opmode_addr, 32'h0);
    `CHK({e, q}, 33'h0, "refused write stored")
    apb(1'b1, opmode_addr, 32'h2002);
    cyc(2);
    `CHK({tx_start_q, rx_start_q}, 2'b11, "processes not restarted")
    $display("test sleep done");
    close_out();
  end
endmodule : tb_top
